// File: bench/cfg_access_ports_tb.sv
// self-checking bench for the configuration access ports
// assumes far_side_model answers both downstream ports
`default_nettype none
module cfg_access_ports_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_port_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        io_valid = 1'b0;
  io_cmd_t     io_cmd = '0;
  logic        io_busy, io_ack, cfg_valid, cfg_ack, pass_valid, pass_ack;
  logic [31:0] io_rdata, cfg_rdata, pass_rdata, selector, s;
  cfg_cmd_t    cfg_cmd;
  io_cmd_t     pass_cmd;
  logic [32:0] note;
  logic [32:0] notes[$];
  logic [31:0] wexp = 32'h0000_0000;
  logic        wexp_wr = 1'b0;
  int          miscompares = 0;
  int          check_count = 0;
  always #5 clk = ~clk;
  cfg_access_ports uut (.clk, .rstn, .io_valid, .io_cmd, .io_busy, .io_ack, .io_rdata, .cfg_valid, .cfg_cmd,
    .cfg_ack, .cfg_rdata, .pass_valid, .pass_cmd, .pass_ack, .pass_rdata, .selector);
  far_side_model fsm (.clk, .rstn, .cfg_valid, .cfg_cmd, .cfg_ack, .cfg_rdata, .pass_valid, .pass_cmd,
    .pass_ack, .pass_rdata);
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [31:0] cfg_exp(logic [31:0] v, logic [3:0] be);
    logic [31:0] r;
    r = {v[23:16], v[15:11], v[10:8], v[7:2], be, 6'h2a};
    for (int i = 0; i < 4; i++) if (!be[i]) r[8*i +: 8] = 8'hff;
    return r;
  endfunction
  // one request, presented for one cycle; answer checked by the monitor
  task automatic io(logic wr, logic [15:0] a, logic [3:0] be, logic [31:0] d, logic chk, logic [31:0] exp);
    int n;
    @(posedge clk);
    wexp     = d;
    wexp_wr  = wr;
    io_valid <= 1'b1;
    io_cmd   <= {wr, a, be, d};
    notes.push_back({chk, exp});
    @(posedge clk);
    io_valid <= 1'b0;
    n = 0;
    #1;
    while (io_ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 50) begin
      miscompares++;
      summarize;
    end
  endtask
  // far side must see the processor's own direction and write data
  always @(posedge clk) if (rstn && cfg_valid && cfg_ack) begin
    cmp("cfg_wr", {31'h0, wexp_wr}, {31'h0, cfg_cmd.wr});
    cmp("cfg_wdata", wexp, cfg_cmd.wdata);
  end
  always @(posedge clk) if (rstn && pass_valid && pass_ack) begin
    cmp("pass_wr", {31'h0, wexp_wr}, {31'h0, pass_cmd.wr});
    cmp("pass_wdata", wexp, pass_cmd.wdata);
  end
  always @(posedge clk) if (rstn && io_ack === 1'b1) begin
    if (notes.size() == 0) begin
      miscompares++;
      $display("wrong value io_ack expected 0 seen 1");
    end else begin
      note = notes.pop_front();
      if (note[32]) cmp("io_rdata", note[31:0], io_rdata);
    end
  end
  initial begin
    #100000;
    miscompares++;
    summarize;
  end
  // a single driver stands for the boot processor
  initial begin
    void'($urandom(32'h9e56_5d4d));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1 cmp("selector", 32'h0000_0000, selector);
    for (int k = 0; k < 8; k++) begin
      s = {k[0], 31'($urandom)};
      io(1'b1, SEL_PORT_ADDR, BE_FULL, s, 1'b0, 32'h0);
      io(1'b0, SEL_PORT_ADDR, BE_FULL, 32'h0, 1'b1, s & SEL_WMASK);
      io(1'b1, SEL_PORT_ADDR, 4'h3, ~s, 1'b0, 32'h0);
      io(1'b0, SEL_PORT_ADDR, 4'h1 << (k % 4), 32'h0, 1'b1, {SEL_PORT_ADDR, 4'h1 << (k % 4), 12'h5a5});
      io(1'b0, SEL_PORT_ADDR, BE_FULL, 32'h0, 1'b1, s & SEL_WMASK);
      for (int b = 0; b < 16; b++)
        io(1'b0, WIN_PORT_ADDR, 4'(b), 32'h0, 1'b1, s[31] ? cfg_exp(s, 4'(b)) : {WIN_PORT_ADDR, 4'(b), 12'h5a5});
      io(1'b1, WIN_PORT_ADDR, 4'(k + 1), $urandom, 1'b0, 32'h0);
    end
    io(1'b0, 16'h0080, BE_FULL, 32'h0, 1'b1, {16'h0080, BE_FULL, 12'h5a5});
    repeat (3) @(posedge clk);
    summarize;
  end
endmodule
`default_nettype wire

// File: bench/far_side_model.sv
// configuration target and downstream I/O target behind the access ports
// assumes one outstanding transfer per port, ack is a one-cycle pulse
`default_nettype none
module far_side_model
  import cfg_port_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // configuration target
  input  wire logic                  cfg_valid,
  input  wire cfg_port_pkg::cfg_cmd_t cfg_cmd,
  output logic                       cfg_ack,
  output logic [31:0]                cfg_rdata,
  // downstream I/O target
  input  wire logic                  pass_valid,
  input  wire cfg_port_pkg::io_cmd_t pass_cmd,
  output logic                       pass_ack,
  output logic [31:0]                pass_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cwait_q;
  logic [1:0] pwait_q;
  // data echoes the request fields so a wrong field shows in the read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
      cwait_q   <= 2'h0;
    end else if (cfg_valid && !cfg_ack && cwait_q == 2'h0) begin
      cfg_ack   <= 1'b1;
      cfg_rdata <= {cfg_cmd.bus, cfg_cmd.dev, cfg_cmd.func, cfg_cmd.regidx, cfg_cmd.be, 6'h2a};
    end else begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= ~cfg_rdata;
      cwait_q   <= cfg_valid ? cwait_q - 2'h1 : 2'($urandom_range(3));
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pass_ack   <= 1'b0;
      pass_rdata <= 32'h0000_0000;
      pwait_q    <= 2'h0;
    end else if (pass_valid && !pass_ack && pwait_q == 2'h0) begin
      pass_ack   <= 1'b1;
      pass_rdata <= {pass_cmd.addr, pass_cmd.be, 12'h5a5};
    end else begin
      pass_ack   <= 1'b0;
      pass_rdata <= ~pass_rdata;
      pwait_q    <= pass_valid ? pwait_q - 2'h1 : 2'($urandom_range(3));
    end
  end
endmodule
`default_nettype wire

// File: logic/cfg_access_ports.sv
// configuration selector and data window ports on the processor I/O path
// assumes one I/O request at a time, dword aligned address with byte enables,
// and targets that answer with a one-cycle ack
`default_nettype none
module cfg_access_ports (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // processor I/O request and answer
  input  wire logic                   io_valid,
  input  wire cfg_port_pkg::io_cmd_t  io_cmd,
  output logic                        io_busy,
  output logic                        io_ack,
  output logic [31:0]                 io_rdata,
  // configuration transfer toward targets
  output logic                        cfg_valid,
  output cfg_port_pkg::cfg_cmd_t      cfg_cmd,
  input  wire logic                   cfg_ack,
  input  wire logic [31:0]            cfg_rdata,
  // ordinary I/O forwarded downstream
  output logic                        pass_valid,
  output cfg_port_pkg::io_cmd_t       pass_cmd,
  input  wire logic                   pass_ack,
  input  wire logic [31:0]            pass_rdata,
  // selector contents for observation
  output logic [31:0]                 selector
);
  import cfg_port_pkg::*;

  state_t      state_q;
  logic        busy_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [31:0] sel_q;
  logic        cfg_valid_q;
  cfg_cmd_t    cfg_cmd_q;
  logic        pass_valid_q;
  io_cmd_t     pass_cmd_q;
  logic [31:0] cfg_merged;

  logic taken;
  logic hit_sel;
  logic hit_win;
  logic sel_full;
  logic win_cfg;
  logic win_none;

  assign taken    = io_valid && !busy_q;
  assign hit_sel  = io_cmd.addr[15:ADDR_DW_LO] == SEL_PORT_ADDR[15:ADDR_DW_LO];
  assign hit_win  = io_cmd.addr[15:ADDR_DW_LO] == WIN_PORT_ADDR[15:ADDR_DW_LO];
  assign sel_full = hit_sel && (io_cmd.be == BE_FULL);
  // window only reaches config space while enabled; otherwise it is plain I/O
  assign win_cfg  = hit_win && sel_q[EN_BIT];
  assign win_none = win_cfg && (io_cmd.be == BE_NONE);

  // disabled lanes read as all ones, like a master abort
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    lane_pick #(.W(8)) u_lane (
      .en   (cfg_cmd_q.be[i]),
      .data (cfg_rdata[8*i+:8]),
      .fill (LANE_FILL),
      .q    (cfg_merged[8*i+:8])
    );
  end

  // sequencing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (taken && win_cfg && !win_none) begin
            state_q <= ST_CFG;
            busy_q  <= 1'b1;
          end else if (taken && !sel_full && !win_cfg) begin
            state_q <= ST_PASS;
            busy_q  <= 1'b1;
          end
        end
        ST_CFG: begin
          if (cfg_ack) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
          end
        end
        ST_PASS: begin
          if (pass_ack) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // selector register: full dword writes only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= SEL_RESET;
    end else if (taken && sel_full && io_cmd.wr) begin
      sel_q <= io_cmd.wdata & SEL_WMASK;
    end
  end

  // configuration transfer request, held until the target acks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_valid_q <= 1'b0;
      cfg_cmd_q   <= '0;
    end else if (state_q == ST_IDLE && taken && win_cfg && !win_none) begin
      cfg_valid_q      <= 1'b1;
      cfg_cmd_q.wr     <= io_cmd.wr;
      cfg_cmd_q.bus    <= sel_q[BUS_HI:BUS_LO];
      cfg_cmd_q.dev    <= sel_q[DEV_HI:DEV_LO];
      cfg_cmd_q.func   <= sel_q[FUNC_HI:FUNC_LO];
      cfg_cmd_q.regidx <= sel_q[REG_HI:REG_LO];
      cfg_cmd_q.be     <= io_cmd.be;
      cfg_cmd_q.wdata  <= io_cmd.wdata;
    end else if (state_q == ST_CFG && cfg_ack) begin
      cfg_valid_q <= 1'b0;
    end
  end

  // ordinary I/O forwarding, held until downstream acks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pass_valid_q <= 1'b0;
      pass_cmd_q   <= '0;
    end else if (state_q == ST_IDLE && taken && !sel_full && !win_cfg) begin
      pass_valid_q <= 1'b1;
      pass_cmd_q   <= io_cmd;
    end else if (state_q == ST_PASS && pass_ack) begin
      pass_valid_q <= 1'b0;
    end
  end

  // answer to the processor
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q   <= 1'b0;
      rdata_q <= SEL_RESET;
    end else begin
      ack_q <= 1'b0;
      if (state_q == ST_IDLE && taken && sel_full) begin
        ack_q   <= 1'b1;
        rdata_q <= io_cmd.wr ? rdata_q : sel_q;
      end else if (state_q == ST_IDLE && taken && win_none) begin
        // no lanes enabled: no target touched, reads float high
        ack_q   <= 1'b1;
        rdata_q <= io_cmd.wr ? rdata_q : {LANES{LANE_FILL}};
      end else if (state_q == ST_CFG && cfg_ack) begin
        ack_q   <= 1'b1;
        rdata_q <= cfg_cmd_q.wr ? rdata_q : cfg_merged;
      end else if (state_q == ST_PASS && pass_ack) begin
        ack_q   <= 1'b1;
        rdata_q <= pass_cmd_q.wr ? rdata_q : pass_rdata;
      end
    end
  end

  assign io_busy    = busy_q;
  assign io_ack     = ack_q;
  assign io_rdata   = rdata_q;
  assign cfg_valid  = cfg_valid_q;
  assign cfg_cmd    = cfg_cmd_q;
  assign pass_valid = pass_valid_q;
  assign pass_cmd   = pass_cmd_q;
  assign selector   = sel_q;

  property p_sel_read;
    @(posedge clk) disable iff (!rstn)
    (taken && sel_full && !io_cmd.wr) |=> (io_ack && io_rdata == $past(sel_q));
  endproperty
  a_sel_read: assert property (p_sel_read)
    else $error("selector read not answered with selector value");

  property p_win_start;
    @(posedge clk) disable iff (!rstn)
    (taken && hit_win && sel_q[EN_BIT] && io_cmd.be != BE_NONE) |=> (cfg_valid && io_busy);
  endproperty
  a_win_start: assert property (p_win_start)
    else $error("window access did not start a config transfer");

  property p_lane_fill;
    @(posedge clk) disable iff (!rstn)
    (state_q == ST_CFG && cfg_ack && !cfg_cmd.wr && !cfg_cmd.be[0]) |=> (io_ack && io_rdata[7:0] == LANE_FILL);
  endproperty
  a_lane_fill: assert property (p_lane_fill)
    else $error("disabled byte lane did not read as fill");

  property p_full_write;
    @(posedge clk) disable iff (!rstn)
    (taken && sel_full && io_cmd.wr) |=> (io_ack && selector == ($past(io_cmd.wdata) & SEL_WMASK));
  endproperty
  a_full_write: assert property (p_full_write)
    else $error("full dword selector write not latched");

  property p_partial_sel;
    @(posedge clk) disable iff (!rstn)
    (taken && hit_sel && io_cmd.be != BE_FULL) |=> (pass_valid && $stable(selector) && !cfg_valid);
  endproperty
  a_partial_sel: assert property (p_partial_sel)
    else $error("partial selector access not forwarded untouched");

  property p_bus_field;
    @(posedge clk) disable iff (!rstn)
    $rose(cfg_valid) |-> cfg_cmd.bus == selector[BUS_HI:BUS_LO];
  endproperty
  a_bus_field: assert property (p_bus_field)
    else $error("bus number does not match selector");

  property p_dev_field;
    @(posedge clk) disable iff (!rstn)
    $rose(cfg_valid) |-> cfg_cmd.dev == selector[DEV_HI:DEV_LO];
  endproperty
  a_dev_field: assert property (p_dev_field)
    else $error("device number does not match selector");

  property p_func_field;
    @(posedge clk) disable iff (!rstn)
    $rose(cfg_valid) |-> cfg_cmd.func == selector[FUNC_HI:FUNC_LO];
  endproperty
  a_func_field: assert property (p_func_field)
    else $error("function number does not match selector");

  property p_reg_field;
    @(posedge clk) disable iff (!rstn)
    $rose(cfg_valid) |-> cfg_cmd.regidx == selector[REG_HI:REG_LO];
  endproperty
  a_reg_field: assert property (p_reg_field)
    else $error("register index does not match selector");

  property p_enable_gate;
    @(posedge clk) disable iff (!rstn)
    (taken && hit_win && !sel_q[EN_BIT]) |=> (!cfg_valid && pass_valid);
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("config transfer started with enable bit clear");
endmodule
`default_nettype wire

// File: logic/cfg_port_pkg.sv
// constants, field layout and carrier types for the configuration access ports
// assumes a dword-wide processor I/O request port and one clock
// How it works
// - a 32-bit selector port answers at I/O address 0CF8h and a 32-bit data window at 0CFCh.
// - once the selector holds a target with bit 31 set, every later data window read or write with any byte enable set starts a configuration transfer to it.
// - byte enables of a data window access choose which bytes of the configuration register take part.
// - a selector access counts as a configuration-mechanism access only when it is a full dword.
// - a partial access to the selector address leaves the selector alone and is forwarded as ordinary I/O.
// - the target bus number is selector bits 23 to 16.
// - the target device number is selector bits 15 to 11.
// - the function number is selector bits 10 to 8.
// - the register index is selector bits 7 to 2.
`default_nettype none
package cfg_port_pkg;
  localparam logic [15:0] SEL_PORT_ADDR = 16'h0CF8;
  localparam logic [15:0] WIN_PORT_ADDR = 16'h0CFC;
  localparam int unsigned ADDR_DW_LO    = 2;
  localparam logic [3:0]  BE_FULL       = 4'hF;
  localparam logic [3:0]  BE_NONE       = 4'h0;
  localparam logic [31:0] SEL_RESET     = 32'h0000_0000;
  localparam logic [31:0] SEL_WMASK     = 32'h80FF_FFFC;
  localparam logic [7:0]  LANE_FILL     = 8'hFF;
  localparam int unsigned EN_BIT        = 31;
  localparam int unsigned BUS_HI        = 23;
  localparam int unsigned BUS_LO        = 16;
  localparam int unsigned DEV_HI        = 15;
  localparam int unsigned DEV_LO        = 11;
  localparam int unsigned FUNC_HI       = 10;
  localparam int unsigned FUNC_LO       = 8;
  localparam int unsigned REG_HI        = 7;
  localparam int unsigned REG_LO        = 2;
  localparam int unsigned LANES         = 4;

  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } io_cmd_t;

  typedef struct packed {
    logic        wr;
    logic [7:0]  bus;
    logic [4:0]  dev;
    logic [2:0]  func;
    logic [5:0]  regidx;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CFG  = 2'b01,
    ST_PASS = 2'b10
  } state_t;
endpackage
`default_nettype wire

// File: logic/lane_pick.sv
// one byte lane of read data: target byte when enabled, fill otherwise
// assumes the caller registers the result
`default_nettype none
module lane_pick #(
  parameter int unsigned W = 8
) (
  // select
  input  wire logic         en,
  // data
  input  wire logic [W-1:0] data,
  input  wire logic [W-1:0] fill,
  output logic      [W-1:0] q
);
  assign q = en ? data : fill;
endmodule
`default_nettype wire
